// ### rtl/tcm_pkg.sv
// Package of constants and types for the Type-C CC mux control block
package tcm_pkg;
    // Tri-level strap codes
    typedef enum logic [1:0] {
        TCM_TRI_FLOAT,
        TCM_TRI_HIGH,
        TCM_TRI_LOW
    } tcm_tri_t;

    // Port role selected by the role strap
    typedef enum logic [1:0] {
        TCM_ROLE_DRP,
        TCM_ROLE_SRC,
        TCM_ROLE_SNK
    } tcm_role_t;

    // Advertised or detected current level
    typedef enum logic [1:0] {
        TCM_CUR_DEFAULT,
        TCM_CUR_MEDIUM,
        TCM_CUR_HIGH
    } tcm_cur_t;

    // Slave address bit that the mode strap sets
    localparam int TCM_ADDR_STRAP_BIT = 6;
    localparam logic [6:0] TCM_ADDR_BASE = 7'h1d;
    // Mux orientation: 0 routes to position 1, 1 to position 2
    localparam logic TCM_ORIENT_RST = 1'b0;
    localparam logic [1:0] TCM_CUR_RST = 2'h0;
    // Last count of the strap settle window after reset release
    localparam logic [2:0] TCM_SETTLE_LAST = 3'h7;

    // Per-event change flags reported by the connector logic
    typedef struct packed {
        logic attach;
        logic orient;
        logic current;
        logic audio;
    } tcm_evt_t;

    // Connector status from CC detection
    typedef struct packed {
        logic sink_attached;
        logic source_attached;
        logic audio_adapter;
        logic flipped;
        tcm_cur_t src_current;
    } tcm_cc_t;
endpackage : tcm_pkg

// ### rtl/tcm_top.sv
// Control logic for a Type-C CC detection and high-speed mux port
//
// Contract
// - Mode strap: float is pin mode; high/low is I2C, address bit 6 1/0.
// - Pin mode role strap: float dual-role, high source, low sink.
// - Sink in pin mode shows source current on two open-drain outputs.
// - Sink in pin mode reuses I2C clock and data pins as current outputs.
// - In I2C mode interrupt output goes low when register contents change.
// - In pin mode same output goes low while an audio adapter is detected.
// - Attach output low when a sink attaches while acting as source.
// - Active-low enable input; high forces the low-power disabled state.
// - CC orientation routes controller pairs to position 1 or 2.
// - In I2C mode software picks default, 1.5A or 3A advertisement.
// - Pin-mode source advertises only default current.
// - Attach output keeps working in I2C mode beside the interrupt.
`timescale 1ns/1ps
module tcm_top
    import tcm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode_strap,
    input wire logic [1:0] role_strap,
    input wire logic enable_n,
    input wire tcm_cc_t cc_status,
    input wire logic bus_power_sense,
    input wire logic [1:0] i2c_cur_sel,
    input wire logic i2c_role_src,
    input wire logic i2c_role_snk,
    input wire logic irq_clear,
    output logic i2c_mode,
    output logic [6:0] i2c_addr,
    output tcm_role_t role,
    output tcm_cur_t adv_current,
    output logic active,
    output logic mux_sel_pos2,
    output logic scl_oe_n,
    output logic sda_oe_n,
    output logic current_detect_lo_oe_n,
    output logic current_detect_hi_oe_n,
    output logic irq_n,
    output logic audio_adapter_flag,
    output logic irq_oe_n,
    output logic attach_flag_n,
    output logic attach_oe_n,
    output tcm_evt_t evt_pending
);
    // ========================================================
    // Input synchronisers
    // Straps and CC status come from analog detection, outside the clock.
    logic [10:0] raw_in;
    wire logic [10:0] stab_in;

    assign raw_in = {mode_strap, role_strap, enable_n,
                     cc_status.sink_attached, cc_status.source_attached,
                     cc_status.audio_adapter, cc_status.flipped,
                     cc_status.src_current};

    // Each bit owns its chain, so every flop has a single driver
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_sync
            logic [2:0] sync_r;
            logic [2:0] sync_nxt;
            logic stab_r;
            logic stab_nxt;
            always_comb begin
                sync_nxt = {sync_r[1:0], raw_in[gi]};
                stab_nxt = stab_r;
                // Only the agreed second and third stages count
                if (sync_r[1] == sync_r[2]) begin
                    stab_nxt = sync_r[2];
                end
            end
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_r <= 3'h0;
                    stab_r <= 1'b0;
                end else begin
                    sync_r <= sync_nxt;
                    stab_r <= stab_nxt;
                end
            end
            assign stab_in[gi] = stab_r;
        end
    endgenerate

    logic [1:0] mode_s, role_s, cur_s;
    logic en_n_s, snk_s, src_s, aud_s, flip_s;
    assign mode_s = stab_in[10:9];
    assign role_s = stab_in[8:7];
    assign en_n_s = stab_in[6];
    assign snk_s = stab_in[5];
    assign src_s = stab_in[4];
    assign aud_s = stab_in[3];
    assign flip_s = stab_in[2];
    assign cur_s = stab_in[1:0];

    // ========================================================
    // Strap capture
    // Straps are latched once after reset; later changes are ignored.
    logic [2:0] settle_r, settle_nxt;
    logic strap_done_r, strap_done_nxt;
    logic i2c_mode_r, i2c_mode_nxt;
    logic addr6_r, addr6_nxt;
    tcm_role_t pin_role_r, pin_role_nxt;

    always_comb begin
        settle_nxt = settle_r;
        strap_done_nxt = strap_done_r;
        i2c_mode_nxt = i2c_mode_r;
        addr6_nxt = addr6_r;
        pin_role_nxt = pin_role_r;
        if (!strap_done_r) begin
            settle_nxt = settle_r + 3'h1;
            if (settle_r == TCM_SETTLE_LAST) begin
                strap_done_nxt = 1'b1;
                case (tcm_tri_t'(mode_s))
                    TCM_TRI_HIGH: begin
                        i2c_mode_nxt = 1'b1;
                        addr6_nxt = 1'b1;
                    end
                    TCM_TRI_LOW: begin
                        i2c_mode_nxt = 1'b1;
                        addr6_nxt = 1'b0;
                    end
                    default: begin
                        i2c_mode_nxt = 1'b0;
                        addr6_nxt = 1'b0;
                    end
                endcase
                case (tcm_tri_t'(role_s))
                    TCM_TRI_HIGH: pin_role_nxt = TCM_ROLE_SRC;
                    TCM_TRI_LOW: pin_role_nxt = TCM_ROLE_SNK;
                    default: pin_role_nxt = TCM_ROLE_DRP;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_r <= 3'h0;
            strap_done_r <= 1'b0;
            i2c_mode_r <= 1'b0;
            addr6_r <= 1'b0;
            pin_role_r <= TCM_ROLE_DRP;
        end else begin
            settle_r <= settle_nxt;
            strap_done_r <= strap_done_nxt;
            i2c_mode_r <= i2c_mode_nxt;
            addr6_r <= addr6_nxt;
            pin_role_r <= pin_role_nxt;
        end
    end

    // ========================================================
    // Operating state and outputs
    logic act;
    tcm_role_t role_w;
    tcm_cur_t adv_w;
    logic src_state;
    assign act = strap_done_r && !en_n_s;

    always_comb begin
        role_w = pin_role_r;
        if (i2c_mode_r) begin
            if (i2c_role_src) begin
                role_w = TCM_ROLE_SRC;
            end else if (i2c_role_snk) begin
                role_w = TCM_ROLE_SNK;
            end else begin
                role_w = TCM_ROLE_DRP;
            end
        end
        adv_w = TCM_CUR_DEFAULT;
        if (i2c_mode_r && i2c_cur_sel <= 2'h2) begin
            adv_w = tcm_cur_t'(i2c_cur_sel);
        end
        // Dual-role counts as source once it sees a sink on CC
        src_state = (role_w == TCM_ROLE_SRC) ||
                    (role_w == TCM_ROLE_DRP && snk_s);
    end

    logic mux_r, mux_nxt;
    logic attach_r, attach_nxt;
    logic lo_r, lo_nxt, hi_r, hi_nxt, aud_r, aud_nxt;
    tcm_evt_t evt_r, evt_nxt;
    logic [3:0] prev_r, prev_nxt;
    logic [3:0] now_w;
    assign now_w = {snk_s | src_s, flip_s, (cur_s != 2'h0), aud_s};

    always_comb begin
        mux_nxt = mux_r;
        if (act && (snk_s || src_s)) begin
            mux_nxt = flip_s;
        end
        attach_nxt = act && src_state && snk_s;
        lo_nxt = 1'b0;
        hi_nxt = 1'b0;
        if (act && !i2c_mode_r && role_w == TCM_ROLE_SNK && src_s) begin
            lo_nxt = (cur_s == 2'h1) || (cur_s == 2'h2);
            hi_nxt = (cur_s == 2'h2);
        end
        aud_nxt = act && !i2c_mode_r && aud_s;
        prev_nxt = act ? now_w : prev_r;
        // A new change wins over a clear in the same cycle
        evt_nxt = evt_r;
        if (irq_clear) begin
            evt_nxt = '0;
        end
        if (act && i2c_mode_r) begin
            evt_nxt = evt_nxt | tcm_evt_t'(now_w ^ prev_r);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_r <= TCM_ORIENT_RST;
            attach_r <= 1'b0;
            lo_r <= 1'b0;
            hi_r <= 1'b0;
            aud_r <= 1'b0;
            prev_r <= 4'h0;
            evt_r <= '0;
        end else begin
            mux_r <= mux_nxt;
            attach_r <= attach_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            aud_r <= aud_nxt;
            prev_r <= prev_nxt;
            evt_r <= evt_nxt;
        end
    end

    // ========================================================
    // Registered data outputs
    // Role and advert follow host inputs directly; a flop keeps
    // these ports from glitching while the host rewrites them.
    tcm_role_t role_r, role_nxt;
    tcm_cur_t adv_r, adv_nxt;
    logic active_r, active_nxt;

    always_comb begin
        role_nxt = role_w;
        adv_nxt = adv_w;
        active_nxt = act;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            role_r <= TCM_ROLE_DRP;
            adv_r <= tcm_cur_t'(TCM_CUR_RST);
            active_r <= 1'b0;
        end else begin
            role_r <= role_nxt;
            adv_r <= adv_nxt;
            active_r <= active_nxt;
        end
    end

    // Enable low means the pin is pulled low by the device
    assign i2c_mode = i2c_mode_r;
    assign i2c_addr = {addr6_r, TCM_ADDR_BASE[5:0]};
    assign role = role_r;
    assign adv_current = adv_r;
    assign active = active_r;
    assign mux_sel_pos2 = mux_r;
    assign current_detect_lo_oe_n = !lo_r;
    assign current_detect_hi_oe_n = !hi_r;
    // I2C slave owns these pins in I2C mode; pin mode drives current code
    assign sda_oe_n = !lo_r;
    assign scl_oe_n = !hi_r;
    // Disabled part keeps its interrupt released; pending bits return later
    assign irq_n = !(i2c_mode_r && act && (evt_r != '0));
    assign audio_adapter_flag = aud_r;
    assign irq_oe_n = i2c_mode_r ? irq_n : !aud_r;
    assign attach_flag_n = !attach_r;
    assign attach_oe_n = !attach_r;
    assign evt_pending = evt_r;
endmodule : tcm_top

// ### sim/tcm_checker.sv
// Assertion checker on the ports of the CC mux control block
`timescale 1ns/1ps
module tcm_checker
    import tcm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable_n,
    input wire logic i2c_mode,
    input wire logic [6:0] i2c_addr,
    input wire tcm_role_t role,
    input wire tcm_cur_t adv_current,
    input wire logic active,
    input wire logic current_detect_lo_oe_n,
    input wire logic current_detect_hi_oe_n,
    input wire logic irq_n,
    input wire logic audio_adapter_flag,
    input wire logic irq_oe_n,
    input wire logic attach_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Port-level relations
    a_cur_pair: assert property (
        !i2c_mode && !current_detect_hi_oe_n |-> !current_detect_lo_oe_n)
        else $error("High current code without low pin");
    a_src_no_cur: assert property (
        !i2c_mode && role == TCM_ROLE_SRC |-> current_detect_lo_oe_n)
        else $error("Current pin pulled in source role");
    a_addr_base: assert property (
        i2c_mode |-> i2c_addr[5:0] == TCM_ADDR_BASE[5:0])
        else $error("Slave address low bits wrong");
    a_irq_i2c_only: assert property (!irq_n |-> i2c_mode)
        else $error("Interrupt low in pin mode");
    a_audio_pin: assert property (
        !i2c_mode && !irq_oe_n |-> audio_adapter_flag)
        else $error("Shared pin low with no adapter");
    a_attach_src: assert property (
        !attach_oe_n |-> role != TCM_ROLE_SNK)
        else $error("Attach pin low in sink role");
    a_pin_adv: assert property (
        !i2c_mode && role == TCM_ROLE_SRC |-> adv_current == TCM_CUR_DEFAULT)
        else $error("Pin-mode source advertises above default");
    a_enable_off: assert property (
        $rose(enable_n) |-> ##[1:6] !active)
        else $error("Disable not taken");
    // Two idle cycles let the registered pins catch up with active
    a_quiet_off: assert property (
        !active [*2] |-> attach_oe_n && irq_oe_n && current_detect_lo_oe_n)
        else $error("Pin pulled while disabled");
endmodule : tcm_checker

// ### sim/tcm_partner.sv
// Connector partner model that presents CC detection status
`timescale 1ns/1ps
module tcm_partner
    import tcm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [1:0] plug_kind,
    input wire tcm_cur_t plug_cur,
    input wire logic plug_flip,
    output tcm_cc_t cc_status
);
    // ==========================================================
    // Kind 0 none, 1 sink, 2 source, 3 audio adapter
    always @(posedge sys_clk) begin
        cc_status.sink_attached <= (plug_kind == 2'h1);
        cc_status.source_attached <= (plug_kind == 2'h2);
        cc_status.audio_adapter <= (plug_kind == 2'h3);
        cc_status.flipped <= plug_flip;
        // A detached line reads default, never the last advertisement
        cc_status.src_current <= (plug_kind == 2'h2) ? plug_cur
            : TCM_CUR_DEFAULT;
    end
endmodule : tcm_partner

// ### sim/tcm_top_tb.sv
// Self-checking testbench for the CC mux control block
`timescale 1ns/1ps
module tcm_top_tb;
    import tcm_pkg::*;
    logic sys_clk, rst_n, enable_n, bus_power_sense, i2c_role_src;
    logic i2c_role_snk, irq_clear, plug_flip, i2c_mode, active;
    logic mux_sel_pos2, scl_oe_n, sda_oe_n, lo_oe_n, hi_oe_n, irq_n;
    logic audio_adapter_flag, irq_oe_n, attach_flag_n, attach_oe_n;
    logic [1:0] mode_strap, role_strap, i2c_cur_sel, plug_kind;
    logic [6:0] i2c_addr;
    tcm_role_t role;
    tcm_cur_t adv_current, plug_cur;
    tcm_evt_t evt_pending;
    tcm_cc_t cc_status;
    int n_errors, cmp_count, cyc, i;
    tcm_partner u_partner (.sys_clk(sys_clk), .plug_kind(plug_kind),
        .plug_cur(plug_cur), .plug_flip(plug_flip), .cc_status(cc_status));
    tcm_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_strap(mode_strap),
        .role_strap(role_strap), .enable_n(enable_n), .cc_status(cc_status),
        .bus_power_sense(bus_power_sense), .i2c_cur_sel(i2c_cur_sel),
        .i2c_role_src(i2c_role_src), .i2c_role_snk(i2c_role_snk),
        .irq_clear(irq_clear), .i2c_mode(i2c_mode), .i2c_addr(i2c_addr),
        .role(role), .adv_current(adv_current), .active(active),
        .mux_sel_pos2(mux_sel_pos2), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
        .current_detect_lo_oe_n(lo_oe_n), .current_detect_hi_oe_n(hi_oe_n),
        .irq_n(irq_n), .audio_adapter_flag(audio_adapter_flag),
        .irq_oe_n(irq_oe_n), .attach_flag_n(attach_flag_n),
        .attach_oe_n(attach_oe_n), .evt_pending(evt_pending));
    // ==========================================================
    // Helpers
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task close_out;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // Straps are latched only after reset, so each strap set reboots
    task reboot(input logic [1:0] m, input logic [1:0] r);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        mode_strap <= m;
        role_strap <= r;
        plug_kind <= 2'h0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge sys_clk);
    endtask : reboot
    task plug(input logic [1:0] k, input logic [1:0] c, input logic f);
        @(posedge sys_clk);
        plug_kind <= k;
        plug_cur <= tcm_cur_t'(c);
        plug_flip <= f;
        repeat (10) @(posedge sys_clk);
    endtask : plug
    task wait_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_n
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, enable_n, bus_power_sense, i2c_role_src} = 4'h0;
        {i2c_role_snk, irq_clear, plug_flip} = 3'h0;
        {mode_strap, role_strap, i2c_cur_sel, plug_kind} = 8'h00;
        plug_cur = TCM_CUR_DEFAULT;
        {n_errors, cmp_count, cyc} = '0;
        reboot(TCM_TRI_FLOAT, TCM_TRI_LOW);
        chk("i2c_mode", i2c_mode, 8'h00);
        chk("role", role, TCM_ROLE_SNK);
        for (i = 0; i < 3; i++) begin
            plug(2'h2, i[1:0], i[0]);
            chk("lo_oe_n", lo_oe_n, i == 0);
            chk("hi_oe_n", hi_oe_n, i != 2);
            chk("sda_oe_n", sda_oe_n, i == 0);
            chk("scl_oe_n", scl_oe_n, i != 2);
            chk("mux", mux_sel_pos2, i[0]);
        end
        plug(2'h3, 2'h0, 1'b0);
        chk("audio_oe_n", irq_oe_n, 8'h00);
        chk("audio_flag", audio_adapter_flag, 8'h01);
        plug(2'h0, 2'h0, 1'b0);
        chk("audio_off", irq_oe_n, 8'h01);
        reboot(TCM_TRI_FLOAT, TCM_TRI_HIGH);
        chk("role", role, TCM_ROLE_SRC);
        plug(2'h1, 2'h0, 1'b0);
        chk("attach", attach_oe_n, 8'h00);
        chk("attach_flag", attach_flag_n, 8'h00);
        chk("adv", adv_current, TCM_CUR_DEFAULT);
        plug(2'h0, 2'h0, 1'b0);
        chk("detach", attach_oe_n, 8'h01);
        reboot(TCM_TRI_FLOAT, TCM_TRI_FLOAT);
        chk("role", role, TCM_ROLE_DRP);
        plug(2'h1, 2'h0, 1'b0);
        chk("drp_attach", attach_oe_n, 8'h00);
        enable_n <= 1'b1;
        wait_n(10);
        chk("active_off", active, 8'h00);
        chk("attach_off", attach_oe_n, 8'h01);
        enable_n <= 1'b0;
        wait_n(10);
        chk("active_on", active, 8'h01);
        reboot(TCM_TRI_HIGH, TCM_TRI_FLOAT);
        chk("i2c_mode", i2c_mode, 8'h01);
        chk("addr", i2c_addr, {1'b1, TCM_ADDR_BASE[5:0]});
        for (i = 0; i < 4; i++) begin
            i2c_cur_sel <= i[1:0];
            wait_n(6);
            chk("adv_sel", adv_current, 8'((i == 3) ? 0 : i));
        end
        i2c_role_src <= 1'b1;
        wait_n(6);
        irq_clear <= 1'b1;
        wait_n(1);
        irq_clear <= 1'b0;
        plug(2'h1, 2'h0, 1'b0);
        chk("irq_set", irq_n, 8'h00);
        chk("attach_i2c", attach_oe_n, 8'h00);
        irq_clear <= 1'b1;
        wait_n(1);
        irq_clear <= 1'b0;
        wait_n(4);
        chk("irq_clr", irq_n, 8'h01);
        chk("evt", evt_pending, 8'h00);
        // Detach first so the role swap never meets a live attach flag
        plug(2'h0, 2'h0, 1'b0);
        i2c_role_src <= 1'b0;
        i2c_role_snk <= 1'b1;
        plug(2'h2, 2'h2, 1'b1);
        chk("i2c_sda", sda_oe_n, 8'h01);
        chk("i2c_scl", scl_oe_n, 8'h01);
        chk("i2c_lo", lo_oe_n, 8'h01);
        chk("i2c_mux", mux_sel_pos2, 8'h01);
        chk("i2c_irq", irq_n, 8'h00);
        reboot(TCM_TRI_LOW, TCM_TRI_FLOAT);
        chk("addr", i2c_addr, {1'b0, TCM_ADDR_BASE[5:0]});
        close_out();
    end
endmodule : tcm_top_tb
bind tcm_top tcm_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .enable_n(enable_n), .i2c_mode(i2c_mode), .i2c_addr(i2c_addr),
    .role(role), .adv_current(adv_current), .active(active),
    .current_detect_lo_oe_n(current_detect_lo_oe_n),
    .current_detect_hi_oe_n(current_detect_hi_oe_n), .irq_n(irq_n),
    .audio_adapter_flag(audio_adapter_flag), .irq_oe_n(irq_oe_n),
    .attach_oe_n(attach_oe_n));
